// ==== acl_defines.svh ====
/*
 Constants for the locked configuration register bank: register indices,
 reset values, the unlock key, the scan mode code and the checksum settings.
 Assumes it is included once per compilation unit through its guard.
*/
`ifndef ACL_DEFINES_SVH
`define ACL_DEFINES_SVH

// Register indices on the four-bit register address
`define ACL_ADDR_GAP 4'h8
`define ACL_ADDR_OFFSET 4'h9
`define ACL_ADDR_GAIN 4'ha
`define ACL_ADDR_FIXB 4'hb
`define ACL_ADDR_FIXC 4'hc
`define ACL_ADDR_KEY 4'hd
`define ACL_ADDR_VARE 4'he
`define ACL_ADDR_CSUM 4'hf

// Reset values
`define ACL_RST_GAP 24'h000000
`define ACL_RST_OFFSET 24'h000000
`define ACL_RST_GAIN 24'h800000
`define ACL_RST_FIXB 24'h900000
`define ACL_RST_FIXC 8'h50
`define ACL_RST_KEY 8'ha5
`define ACL_RST_VARE 16'h000c
`define ACL_RST_CSUM 16'h0000

// Key value that leaves the map open
`define ACL_UNLOCK_KEY 8'ha5

// Conversion mode code that runs the sequencer with timed gaps
`define ACL_MODE_TIMED_SCAN 2'b11

// Gain of one is 2^23, so the product is shifted right by 23
`define ACL_GAIN_SHIFT 23
`define ACL_RES_MAX 24'h7fffff
`define ACL_RES_MIN 24'h800000

// Checksum generator: polynomial, start value, bits covered
`define ACL_CRC_POLY 16'h8005
`define ACL_CRC_INIT 16'h0000
`define ACL_MAP_BITS 128

`endif

// ==== acl_pkg.sv ====
/*
 Types shared by the locked configuration register bank.
 Assumes acl_defines.svh is on the include path.
*/
package acl_pkg;

   // One register access from the serial front end
   typedef struct packed {
      logic wr;
      logic [3:0] addr;
      logic [23:0] data;
   } acl_req_t;

   // One conversion result word
   typedef struct packed {
      logic valid;
      logic [23:0] data;
   } acl_result_t;

   // Gap timer states
   typedef enum logic [0:0] {
      ACL_GAP_IDLE = 1'b0,
      ACL_GAP_WAIT = 1'b1
   } acl_gap_state_t;

endpackage : acl_pkg

// ==== acl_regs.sv ====
/*
 Upper configuration register bank of a delta-sigma converter: scan gap
 timer, offset and gain correction of results, fixed words, write lock key
 and the map checksum. Assumes the serial front end decodes frames and
 presents one access per cycle on the same clock, and that the sequencer
 pulses seq_done at the end of each multi-channel cycle.
*/
`timescale 1ns/100ps
`include "acl_defines.svh"

module acl_regs
   import acl_pkg::*;
#(
   parameter logic [15:0] VARIANT_RESET = `ACL_RST_VARE
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register access from the serial front end
   input wire acl_req_t req,
   output logic [23:0] rd_data,
   // Sequencer handshake
   input wire logic [1:0] conversion_mode_field,
   input wire logic seq_done,
   output logic seq_start,
   output logic gap_busy,
   // Conversion results
   input wire acl_result_t raw_result,
   output acl_result_t corr_result,
   // Lock state
   output logic map_locked
);

   // Register file
   logic [23:0] gap_q, gap_d;
   logic [23:0] offset_q, offset_d;
   logic [23:0] gain_q, gain_d;
   logic [23:0] fixb_q, fixb_d;
   logic [7:0] fixc_q, fixc_d;
   logic [7:0] key_q, key_d;
   logic [15:0] vare_q, vare_d;
   logic [15:0] csum_q, csum_d;
   logic [23:0] rd_q, rd_d;
   // Gap timer
   acl_gap_state_t gst_q, gst_d;
   logic [23:0] gcnt_q, gcnt_d;
   logic start_q, start_d;
   // Result path
   acl_result_t res_q, res_d;

   logic locked;
   logic wr_ok;

   // Bitwise CRC over the whole configuration image, msb first
   function automatic logic [15:0] acl_crc(input logic [`ACL_MAP_BITS-1:0] img);
      logic [15:0] c;
      logic fb;
      c = `ACL_CRC_INIT;
      for (int i = `ACL_MAP_BITS - 1; i >= 0; i--) begin
         fb = c[15] ^ img[i];
         c = {c[14:0], 1'b0};
         if (fb) begin
            c = c ^ `ACL_CRC_POLY;
         end
      end
      return c;
   endfunction : acl_crc

   // Clamp a wide signed value into the 24-bit result range
   function automatic logic [23:0] acl_sat(input logic signed [49:0] v);
      logic [23:0] r;
      if (v > $signed({26'h0, `ACL_RES_MAX})) begin
         r = `ACL_RES_MAX;
      end else if (v < $signed({26'h3ffffff, `ACL_RES_MIN})) begin
         r = `ACL_RES_MIN;
      end else begin
         r = v[23:0];
      end
      return r;
   endfunction : acl_sat

   assign locked = (key_q != `ACL_UNLOCK_KEY);
   // Key register stays writable so a locked host can still unlock
   assign wr_ok = req.wr && (!locked || req.addr == `ACL_ADDR_KEY);

   // Register writes, read mux and checksum
   always_comb begin
      gap_d = gap_q;
      offset_d = offset_q;
      gain_d = gain_q;
      fixb_d = fixb_q;
      fixc_d = fixc_q;
      key_d = key_q;
      vare_d = vare_q;
      // A refused write simply falls through: every register holds
      if (wr_ok) begin
         unique case (req.addr)
            `ACL_ADDR_GAP: gap_d = req.data;
            `ACL_ADDR_OFFSET: offset_d = req.data;
            `ACL_ADDR_GAIN: gain_d = req.data;
            `ACL_ADDR_FIXB: fixb_d = req.data; // Host keeps the fixed value
            `ACL_ADDR_FIXC: fixc_d = req.data[7:0];
            `ACL_ADDR_KEY: key_d = req.data[7:0];
            `ACL_ADDR_VARE: vare_d = req.data[15:0];
            default: ; // Lower map is not held here; checksum is read only
         endcase
      end
      // Recomputed every clock while locked, forced to zero when open
      if (locked) begin
         csum_d = acl_crc({gap_q, offset_q, gain_q, fixb_q, fixc_q, key_q, vare_q});
      end else begin
         csum_d = `ACL_RST_CSUM;
      end
      unique case (req.addr)
         `ACL_ADDR_GAP: rd_d = gap_q;
         `ACL_ADDR_OFFSET: rd_d = offset_q;
         `ACL_ADDR_GAIN: rd_d = gain_q;
         `ACL_ADDR_FIXB: rd_d = fixb_q;
         `ACL_ADDR_FIXC: rd_d = {16'h0000, fixc_q};
         `ACL_ADDR_KEY: rd_d = {16'h0000, key_q};
         `ACL_ADDR_VARE: rd_d = {8'h00, vare_q};
         `ACL_ADDR_CSUM: rd_d = {8'h00, csum_q};
         default: rd_d = 24'h000000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gap_q <= `ACL_RST_GAP;
         offset_q <= `ACL_RST_OFFSET;
         gain_q <= `ACL_RST_GAIN;
         fixb_q <= `ACL_RST_FIXB;
         fixc_q <= `ACL_RST_FIXC;
         key_q <= `ACL_RST_KEY;
         vare_q <= VARIANT_RESET;
         csum_q <= `ACL_RST_CSUM;
         rd_q <= 24'h000000;
      end else begin
         gap_q <= gap_d;
         offset_q <= offset_d;
         gain_q <= gain_d;
         fixb_q <= fixb_d;
         fixc_q <= fixc_d;
         key_q <= key_d;
         vare_q <= vare_d;
         csum_q <= csum_d;
         rd_q <= rd_d;
      end
   end

   // Gap timer between scan cycles; gap value sampled when a cycle ends
   always_comb begin
      gst_d = gst_q;
      gcnt_d = gcnt_q;
      start_d = 1'b0;
      unique case (gst_q)
         ACL_GAP_IDLE: begin
            if (seq_done && conversion_mode_field == `ACL_MODE_TIMED_SCAN) begin
               if (gap_q == 24'h000000) begin
                  start_d = 1'b1; // No gap inserted
               end else begin
                  gst_d = ACL_GAP_WAIT;
                  gcnt_d = gap_q;
               end
            end
         end
         ACL_GAP_WAIT: begin
            // Leaving timed scan mode abandons the wait without a start
            if (conversion_mode_field != `ACL_MODE_TIMED_SCAN) begin
               gst_d = ACL_GAP_IDLE;
               gcnt_d = 24'h000000;
            end else if (gcnt_q == 24'h000001) begin
               gst_d = ACL_GAP_IDLE;
               gcnt_d = 24'h000000;
               start_d = 1'b1;
            end else begin
               gcnt_d = gcnt_q - 24'h000001;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gst_q <= ACL_GAP_IDLE;
         gcnt_q <= 24'h000000;
         start_q <= 1'b0;
      end else begin
         gst_q <= gst_d;
         gcnt_q <= gcnt_d;
         start_q <= start_d;
      end
   end

   // Offset then gain correction; one register stage keeps timing short
   always_comb begin
      logic signed [24:0] sum;
      logic signed [49:0] prod;
      sum = 25'sh0;
      prod = 50'sh0;
      res_d.valid = raw_result.valid;
      res_d.data = res_q.data;
      if (raw_result.valid) begin
         sum = $signed({raw_result.data[23], raw_result.data}) + $signed({offset_q[23], offset_q});
         prod = (50'(sum) * $signed({26'h0, gain_q})) >>> `ACL_GAIN_SHIFT;
         res_d.data = acl_sat(prod);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         res_q <= '0;
      end else begin
         res_q <= res_d;
      end
   end

   // Outputs
   assign rd_data = rd_q;
   assign seq_start = start_q;
   assign gap_busy = (gst_q == ACL_GAP_WAIT);
   assign corr_result = res_q;
   assign map_locked = locked;

endmodule : acl_regs

// ==== acl_regs_assertions.sv ====
/* Port checker for acl_regs.
 Bound from tb_top; sees only the bank's ports. */
`timescale 1ns/100ps
module acl_regs_chk
   import acl_pkg::*;
(
   // Clock, reset, register port
   input wire logic clk,
   input wire logic rst_n,
   input wire acl_req_t req,
   input wire logic [23:0] rd_data,
   // Sequencer, results, lock
   input wire logic [1:0] conversion_mode_field,
   input wire logic seq_done,
   input wire logic seq_start,
   input wire logic gap_busy,
   input wire acl_result_t raw_result,
   input wire acl_result_t corr_result,
   input wire logic map_locked
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // The key register stays writable in both states
   property p_unlock; req.wr && req.addr == 4'hd && req.data[7:0] == 8'ha5 |=> !map_locked; endproperty
   a_unlock: assert property (p_unlock) else $error("unlock");
   property p_lock; req.wr && req.addr == 4'hd && req.data[7:0] != 8'ha5 |=> map_locked; endproperty
   a_lock: assert property (p_lock) else $error("lock");
   // Settled open map reads a zero checksum
   property p_csum0; !map_locked && $past(!map_locked) && req.addr == 4'hf |=> rd_data == 24'h0; endproperty
   a_csum0: assert property (p_csum0) else $error("csum");
   property p_gap; seq_done && conversion_mode_field == 2'b11 && !gap_busy |=> seq_start || gap_busy; endproperty
   a_gap: assert property (p_gap) else $error("gap");
   // Outside timed scan no cycle may be launched
   property p_mode; conversion_mode_field != 2'b11 |=> !seq_start; endproperty
   a_mode: assert property (p_mode) else $error("mode");
   property p_pulse; seq_start |=> !seq_start && !gap_busy; endproperty
   a_pulse: assert property (p_pulse) else $error("pulse");
   property p_valid; 1'b1 |=> corr_result.valid == $past(raw_result.valid); endproperty
   a_valid: assert property (p_valid) else $error("valid");
   property p_hold; !raw_result.valid |=> $stable(corr_result.data); endproperty
   a_hold: assert property (p_hold) else $error("hold");
endmodule : acl_regs_chk

// ==== acl_host.sv ====
/* Host model: one register access per wr or rd call.
 Assumes reads answer one edge after the index. */
`timescale 1ns/100ps
`include "acl_defines.svh"
module acl_host
   import acl_pkg::*;
(
   // Clock and register port
   input wire logic clk,
   input wire logic [23:0] rd_data,
   output acl_req_t req
);
   initial req = '0;
   // Strobe lasts one edge; next call lets an edge pass
   task automatic wr(input logic [3:0] a, input logic [23:0] d);
      @(posedge clk) req <= '{1'b1, a, d};
      @(posedge clk) req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [23:0] d);
      @(posedge clk) req <= '{1'b0, a, 24'h0};
      @(posedge clk) #1 d = rd_data;
   endtask : rd
   // Fixed words only ever get their required values
   task automatic keep_fixed;
      wr(`ACL_ADDR_FIXB, `ACL_RST_FIXB);
      wr(`ACL_ADDR_FIXC, {16'h0, `ACL_RST_FIXC});
      wr(`ACL_ADDR_VARE, {8'h0, `ACL_RST_VARE});
   endtask : keep_fixed
endmodule : acl_host

// ==== tb_top.sv ====
/* Self-checking bench for acl_regs.
 Host model drives the map; bench drives sequencer and results. */
`timescale 1ns/100ps
`include "acl_defines.svh"
module tb_top
   import acl_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] mode = 2'b11;
   logic seq_done = 1'b0;
   acl_result_t raw = '0;
   acl_result_t corr;
   acl_req_t req;
   logic [23:0] rd_data, v;
   logic seq_start, gap_busy, map_locked;
   logic [23:0] rst_tab [8] = '{24'h0, 24'h0, 24'h800000, 24'h900000, 24'h50, 24'ha5, 24'hc, 24'h0};
   logic [23:0] gaps [2] = '{24'h0, 24'h3};
   logic [127:0] map;
   int error_cnt = 0;
   int n_tests = 0;
   int i;
   // 250 MHz clock
   always #2 clk = ~clk;
   acl_host host_u (.clk(clk), .rd_data(rd_data), .req(req));
   acl_regs dut_u (.clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data), .conversion_mode_field(mode),
      .seq_done(seq_done), .seq_start(seq_start), .gap_busy(gap_busy), .raw_result(raw),
      .corr_result(corr), .map_locked(map_locked));
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // One result strobe; corrected word and its strobe stand one edge later
   task automatic send_raw(input logic [23:0] d, input logic [23:0] exp);
      @(posedge clk) raw <= '{1'b1, d};
      @(posedge clk) raw.valid <= 1'b0;
      #1 check(corr.data, exp);
      check({23'h0, corr.valid}, 24'h1);
   endtask : send_raw
   // Reference checksum, msb of the map first
   function automatic logic [15:0] crc(input logic [127:0] m);
      logic [15:0] c;
      c = `ACL_CRC_INIT;
      for (int k = 127; k >= 0; k--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ m[k]) ? `ACL_CRC_POLY : 16'h0);
      end
      return c;
   endfunction : crc
   task automatic give_verdict;
      $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 8; i++) begin
         host_u.rd(4'h8 + i[3:0], v);
         check(v, rst_tab[i]);
      end
      $display("reset values done");
      // Reset gain is exactly one and reset offset is zero
      send_raw(24'h000100, 24'h000100);
      host_u.keep_fixed();
      host_u.wr(`ACL_ADDR_OFFSET, 24'hfffff0);
      host_u.wr(`ACL_ADDR_GAIN, 24'h400000);
      // Minus 16, then half gain: (256 - 16) / 2
      send_raw(24'h000100, 24'h000078);
      $display("correction done");
      // Zero gap and a short gap
      for (int j = 0; j < 2; j++) begin
         host_u.wr(`ACL_ADDR_GAP, gaps[j]);
         @(posedge clk) seq_done <= 1'b1;
         @(posedge clk) seq_done <= 1'b0;
         #1 i = 1;
         check({23'h0, gap_busy}, (gaps[j] != 24'h0) ? 24'h1 : 24'h0);
         while (seq_start !== 1'b1 && i < 50) begin
            @(posedge clk) #1 i++;
         end
         check(i[23:0], gaps[j] + 24'h1);
      end
      // Leaving timed scan mid-gap must abandon the pending start
      @(posedge clk) seq_done <= 1'b1;
      @(posedge clk) seq_done <= 1'b0;
      #1 check({23'h0, gap_busy}, 24'h1);
      @(posedge clk) mode <= 2'b00;
      repeat (5) begin
         @(posedge clk) #1 check({23'h0, seq_start}, 24'h0);
      end
      check({23'h0, gap_busy}, 24'h0);
      // Outside timed scan a finished cycle starts nothing
      @(posedge clk) seq_done <= 1'b1;
      @(posedge clk) seq_done <= 1'b0;
      #1 check({22'h0, gap_busy, seq_start}, 24'h0);
      $display("gap done");
      host_u.wr(`ACL_ADDR_KEY, 24'h0);
      host_u.wr(`ACL_ADDR_GAP, 24'h7);
      host_u.rd(`ACL_ADDR_GAP, v);
      check(v, 24'h3);
      check({23'h0, map_locked}, 24'h1);
      map = {24'h3, 24'hfffff0, 24'h400000, 24'h900000, 8'h50, 8'h00, `ACL_RST_VARE};
      host_u.rd(`ACL_ADDR_CSUM, v);
      check(v, {8'h0, crc(map)});
      // Another locking key: key stays writable and the checksum follows it
      host_u.wr(`ACL_ADDR_KEY, 24'h3c);
      map[23:16] = 8'h3c;
      host_u.rd(`ACL_ADDR_CSUM, v);
      check(v, {8'h0, crc(map)});
      host_u.wr(`ACL_ADDR_KEY, 24'ha5);
      host_u.rd(`ACL_ADDR_CSUM, v);
      check(v, 24'h0);
      check({23'h0, map_locked}, 24'h0);
      $display("lock done");
      give_verdict();
   end
   // Watchdog: the run needs under 300 cycles
   initial begin
      #4000;
      error_cnt++;
      give_verdict();
   end
endmodule : tb_top
bind acl_regs acl_regs_chk chk_u (.clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data),
   .conversion_mode_field(conversion_mode_field), .seq_done(seq_done), .seq_start(seq_start),
   .gap_busy(gap_busy), .raw_result(raw_result), .corr_result(corr_result), .map_locked(map_locked));
